// ==== logic/mbf_defines.svh ====
/*
 * constants of the serial frame engine: timing, offsets, codes.
 * assumes a 20 MHz ref_clk; included by its bare name.
 */
// Function
// - crc accumulator starts at all ones
// - data bits xor into low byte
// - shift right, zero in, keep flag
// - flag one means xor with a001
// - eight shift steps for every byte
// - check field sent low byte first
// - frames delimited by 3.5 character silence
// - long gap drops partial frame, restarts
// - bit rates 9600, 19200, 38400 selectable
// - parity none, odd or even selectable
// - station address 1 to 247 only
// - reply only to own station address
// - registers 4x space, bits 0x space
// - code 01 unicast, 10-20 ms answer
// - code 03 unicast, 10-20 ms answer
// - code 05 broadcastable, 10-20 ms answer
// - code 06 broadcastable, 10-50 ms answer
// - code 15 broadcastable, 10-20 ms answer
// - code 16 broadcastable, 10-50 ms per register
// - code 43 unicast, 10-20 ms answer
// - start, 8 data, parity or second stop
// - broadcast executed but never answered
// - parity or syntax fault ignores frame
`ifndef MBF_DEFINES_SVH
`define MBF_DEFINES_SVH
`define MBF_CLK_HZ 20000000
`define MBF_CLK_NS 50
`define MBF_BIT_9600 12'((`MBF_CLK_HZ) / 9600)
`define MBF_BIT_19200 12'((`MBF_CLK_HZ) / 19200)
`define MBF_BIT_38400 12'((`MBF_CLK_HZ) / 38400)
`define MBF_SIL_9600_NS 4010000
`define MBF_SIL_19200_NS 2005000
`define MBF_SIL_38400_NS 1003000
`define MBF_CYC(ns) (((ns) + `MBF_CLK_NS - 1) / `MBF_CLK_NS)
`define MBF_MS_NS 1000000
`define MBF_RSP_MIN_MS 16'd10
`define MBF_RSP_MAX_SHORT_MS 16'd20
`define MBF_RSP_MAX_LONG_MS 16'd50
`define MBF_CRC_INIT 16'hffff
`define MBF_CRC_POLY 16'ha001
`define MBF_MAX_LEN 8'd128
`define MBF_MIN_LEN 8'd4
`define MBF_ADDR_MAX 8'hf7
`define MBF_BCAST 8'h00
`define MBF_FC_RD_BITS 8'h01
`define MBF_FC_RD_REGS 8'h03
`define MBF_FC_WR_BIT 8'h05
`define MBF_FC_WR_REG 8'h06
`define MBF_FC_WR_BITS 8'h0f
`define MBF_FC_WR_REGS 8'h10
`define MBF_FC_DEV_ID 8'h2b
`define MBF_IDX_FC 7'd1
`define MBF_IDX_QTY_LO 7'd5
`define MBF_OFF_CTRL 5'h00
`define MBF_OFF_STAT 5'h04
`define MBF_OFF_RXIDX 5'h08
`define MBF_OFF_RXDAT 5'h0c
`define MBF_OFF_TXDAT 5'h10
`define MBF_OFF_TXCMD 5'h14
`define MBF_CMD_SEND 0
`define MBF_CMD_DROP 1
`define MBF_RESP_OK 2'b00
`define MBF_RESP_ERR 2'b10
`endif

// ==== logic/mbf_pkg.sv ====
/*
 * types of the serial frame engine.
 * assumes nothing beyond the defines header.
 */
package mbf_pkg;
  // software control word
  typedef struct packed {
    logic [18:0] unused;
    logic en;          // engine enable
    logic [1:0] par;   // 0 none, 1 odd, 2 even
    logic [1:0] baud;  // 0 9600, 1 19200, else 38400
    logic [7:0] addr;  // station address
  } mbf_ctrl_t;
  // status word
  typedef struct packed {
    logic [7:0] fc;
    logic [7:0] len;
    logic [1:0] unused;
    logic late;
    logic tx_busy;
    logic bcast;
    logic par_err;
    logic crc_err;
    logic pending;
  } mbf_stat_t;
  typedef enum logic [4:0] {
    MBF_IDLE = 5'b00001,
    MBF_START = 5'b00010,
    MBF_DATA = 5'b00100,
    MBF_PAR = 5'b01000,
    MBF_STOP = 5'b10000
  } mbf_ser_t;
endpackage

// ==== logic/mbf_crc8.sv ====
/*
 * one byte of crc-16 update, purely combinational.
 * assumes the caller holds the accumulator.
 */
`timescale 1ns/10ps
`include "mbf_defines.svh"
module mbf_crc8 (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  output logic [15:0] crc_out
);
  // eight shift steps, flag decides the polynomial xor
  always_comb begin
    logic [15:0] c;
    logic flag;
    c = crc_in ^ {8'h00, data};
    flag = 1'b0;
    for (int i = 0; i < 8; i++) begin
      flag = c[0];
      c = {1'b0, c[15:1]};
      if (flag) begin
        c = c ^ `MBF_CRC_POLY;
      end
    end
    crc_out = c;
  end
endmodule

// ==== logic/mbf_sync3.sv ====
/*
 * three-stage synchroniser with agreement filter for a pin.
 * assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/10ps
module mbf_sync3 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1; // metastable stage, read only by s2
  logic s2;
  logic s3;
  // idle line is high, so reset to one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      dout <= 1'b1;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// ==== logic/mbf_framer.sv ====
/*
 * rtu slave frame engine: serial receive and transmit, silence framing,
 * crc check and generation, address and function filter, reply timing,
 * axi4-lite register slave.
 * assumes one ref_clk domain at 20 MHz and software that builds replies.
 */
`timescale 1ns/10ps
`include "mbf_defines.svh"
module mbf_framer #(
  parameter int SIL_9600_CYC = `MBF_CYC(`MBF_SIL_9600_NS),
  parameter int SIL_19200_CYC = `MBF_CYC(`MBF_SIL_19200_NS),
  parameter int SIL_38400_CYC = `MBF_CYC(`MBF_SIL_38400_NS),
  parameter int MS_CYC = `MBF_CYC(`MBF_MS_NS)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rxd,
  output logic txd,
  output logic tx_en,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mbf_pkg::*;

  mbf_ctrl_t ctrl; // software settings
  mbf_stat_t stat; // engine status
  logic [7:0] rx_buf [0:127]; // received frame
  logic [7:0] tx_buf [0:127]; // reply body from software
  logic rx_lvl; // filtered line level
  mbf_ser_t rx_st;
  mbf_ser_t tx_st;
  logic [11:0] rx_cnt;
  logic [11:0] tx_cnt;
  logic [2:0] rx_bit;
  logic [2:0] tx_bit;
  logic [7:0] rx_sh;
  logic rx_pok; // running parity check
  logic rx_stb; // byte received, one cycle
  logic rx_perr; // byte had parity or stop fault
  logic [16:0] sil_cnt;
  logic fr_act; // a frame is being collected
  logic fr_bad;
  logic [7:0] fr_len;
  logic [15:0] rx_crc;
  logic [15:0] rx_crc_nx;
  logic fr_end; // silence closed a frame
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_nx;
  logic [7:0] tx_len;
  logic [7:0] tx_pos;
  logic [7:0] tx_byte;
  logic tx_par;
  logic tx_stop2;
  logic tx_go; // send requested, waiting for minimum delay
  logic [16:0] ms_cnt;
  logic [15:0] rsp_ms; // ms since frame accepted
  logic [15:0] rsp_max;
  logic [6:0] rx_idx;
  logic aw_got;
  logic w_got;
  logic [4:0] aw_a;
  logic [31:0] w_d;
  logic wr_do;
  logic [11:0] bit_lim;
  logic [16:0] sil_lim;
  logic fc_ok;
  logic fc_bc;
  logic addr_ok;
  logic [7:0] fc;

  mbf_sync3 u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .din(rxd),
    .dout(rx_lvl)
  );
  mbf_crc8 u_rxcrc (
    .crc_in(rx_crc),
    .data(rx_sh),
    .crc_out(rx_crc_nx)
  );
  mbf_crc8 u_txcrc (
    .crc_in(tx_crc),
    .data(w_d[7:0]),
    .crc_out(tx_crc_nx)
  );

  // rate-dependent counts, all from the one clock
  always_comb begin
    case (ctrl.baud)
      2'd0: begin
        bit_lim = `MBF_BIT_9600;
        sil_lim = 17'(SIL_9600_CYC);
      end
      2'd1: begin
        bit_lim = `MBF_BIT_19200;
        sil_lim = 17'(SIL_19200_CYC);
      end
      default: begin
        bit_lim = `MBF_BIT_38400;
        sil_lim = 17'(SIL_38400_CYC);
      end
    endcase
  end

  // function filter; bits in 0x space, registers in 4x space
  assign fc = rx_buf[`MBF_IDX_FC];
  always_comb begin
    fc_ok = 1'b1;
    fc_bc = 1'b0;
    case (fc)
      `MBF_FC_RD_BITS, `MBF_FC_RD_REGS, `MBF_FC_DEV_ID: fc_bc = 1'b0;
      `MBF_FC_WR_BIT, `MBF_FC_WR_REG: fc_bc = 1'b1;
      `MBF_FC_WR_BITS, `MBF_FC_WR_REGS: fc_bc = 1'b1;
      default: fc_ok = 1'b0; // unknown code counts as a syntax fault
    endcase
  end
  // station must be in range to answer anything but broadcast
  assign addr_ok = (rx_buf[0] == ctrl.addr) && (ctrl.addr != `MBF_BCAST)
    && (ctrl.addr <= `MBF_ADDR_MAX);

  // answer deadline: code 16 scales with register count
  always_comb begin
    case (stat.fc)
      `MBF_FC_WR_REG: rsp_max = `MBF_RSP_MAX_LONG_MS;
      `MBF_FC_WR_REGS: rsp_max = 16'(`MBF_RSP_MAX_LONG_MS * rx_buf[`MBF_IDX_QTY_LO]);
      default: rsp_max = `MBF_RSP_MAX_SHORT_MS;
    endcase
  end

  // serial receiver, half-bit start check then mid-bit sampling
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_st <= MBF_IDLE;
      rx_cnt <= 12'h000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_pok <= 1'b0;
      rx_stb <= 1'b0;
      rx_perr <= 1'b0;
    end else if (ce) begin
      rx_stb <= 1'b0;
      rx_cnt <= rx_cnt + 12'h001;
      case (rx_st)
        MBF_IDLE: begin
          rx_cnt <= 12'h000;
          if (!rx_lvl && ctrl.en && !tx_en) begin
            rx_st <= MBF_START;
          end
        end
        MBF_START: begin
          if (rx_cnt == (bit_lim >> 1)) begin
            rx_cnt <= 12'h000;
            rx_bit <= 3'h0;
            rx_pok <= ctrl.par[0]; // odd parity starts at one
            // a glitch shorter than half a bit is not a start
            rx_st <= rx_lvl ? MBF_IDLE : MBF_DATA;
          end
        end
        MBF_DATA: begin
          if (rx_cnt == bit_lim) begin
            rx_cnt <= 12'h000;
            rx_sh <= {rx_lvl, rx_sh[7:1]};
            rx_pok <= rx_pok ^ rx_lvl;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_st <= (ctrl.par == 2'd0) ? MBF_STOP : MBF_PAR;
            end
          end
        end
        MBF_PAR: begin
          if (rx_cnt == bit_lim) begin
            rx_cnt <= 12'h000;
            rx_pok <= rx_pok ^ rx_lvl;
            rx_st <= MBF_STOP;
          end
        end
        MBF_STOP: begin
          if (rx_cnt == bit_lim) begin
            rx_stb <= 1'b1;
            // a missing stop bit is treated like a parity fault
            rx_perr <= (ctrl.par != 2'd0 && rx_pok) || !rx_lvl;
            rx_st <= MBF_IDLE;
          end
        end
        default: rx_st <= MBF_IDLE;
      endcase
    end
  end

  // silence timer, held at zero while the receiver is busy with a character
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sil_cnt <= 17'h00000;
    end else if (ce) begin
      if (rx_st != MBF_IDLE) begin
        sil_cnt <= 17'h00000;
      end else if (sil_cnt != sil_lim) begin
        sil_cnt <= sil_cnt + 17'h00001;
      end
    end
  end
  assign fr_end = fr_act && (sil_cnt == sil_lim) && (rx_st == MBF_IDLE);

  // frame collection; a long gap closes it, next byte opens a new one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fr_act <= 1'b0;
      fr_bad <= 1'b0;
      fr_len <= 8'h00;
      rx_crc <= `MBF_CRC_INIT;
    end else if (ce) begin
      if (rx_stb) begin
        fr_act <= 1'b1;
        if (fr_len == `MBF_MAX_LEN || rx_perr || stat.pending) begin
          fr_bad <= 1'b1;
        end else begin
          fr_len <= fr_len + 8'h01;
          rx_crc <= rx_crc_nx;
        end
      end else if (fr_end) begin
        fr_act <= 1'b0;
        fr_bad <= 1'b0;
        fr_len <= 8'h00;
        rx_crc <= `MBF_CRC_INIT;
      end
    end
  end

  // receive buffer; frozen while a frame waits for software
  always_ff @(posedge ref_clk) begin
    if (ce && rx_stb && !stat.pending && fr_len != `MBF_MAX_LEN) begin
      rx_buf[fr_len[6:0]] <= rx_sh;
    end
  end

  // frame verdict, errors and reply timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat <= '0;
      ms_cnt <= 17'h00000;
      rsp_ms <= 16'h0000;
    end else if (ce) begin
      ms_cnt <= (ms_cnt == 17'(MS_CYC - 1)) ? 17'h00000 : ms_cnt + 17'h00001;
      if (ms_cnt == 17'(MS_CYC - 1) && rsp_ms != 16'hffff) begin
        rsp_ms <= rsp_ms + 16'h0001;
      end
      stat.tx_busy <= tx_en;
      if (wr_do && aw_a == `MBF_OFF_STAT) begin
        stat.crc_err <= 1'b0;
        stat.par_err <= 1'b0;
        stat.late <= 1'b0;
      end
      if (wr_do && aw_a == `MBF_OFF_TXCMD && w_d[`MBF_CMD_DROP]) begin
        stat.pending <= 1'b0; // broadcast done or request abandoned
      end
      if (wr_do && aw_a == `MBF_OFF_TXCMD && w_d[`MBF_CMD_SEND] && rsp_ms > rsp_max) begin
        stat.late <= 1'b1;
      end
      if (tx_st == MBF_STOP && tx_cnt == bit_lim && !tx_stop2
          && tx_pos == tx_len + 8'h01) begin
        stat.pending <= 1'b0;
      end
      if (fr_end && fr_bad) begin
        stat.par_err <= 1'b1;
      end else if (fr_end && fr_len >= `MBF_MIN_LEN && rx_crc != 16'h0000) begin
        stat.crc_err <= 1'b1;
      end else if (fr_end && fr_len >= `MBF_MIN_LEN && fc_ok
                   && (addr_ok || (rx_buf[0] == `MBF_BCAST && fc_bc))) begin
        stat.pending <= 1'b1;
        stat.bcast <= (rx_buf[0] == `MBF_BCAST);
        stat.len <= fr_len;
        stat.fc <= fc;
        rsp_ms <= 16'h0000;
        ms_cnt <= 17'h00000;
      end
    end
  end

  // reply assembly; the check field accumulates as bytes are written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_len <= 8'h00;
      tx_crc <= `MBF_CRC_INIT;
      tx_go <= 1'b0;
    end else if (ce) begin
      if (wr_do && aw_a == `MBF_OFF_TXDAT && !tx_en && tx_len != `MBF_MAX_LEN - 8'h02) begin
        tx_len <= tx_len + 8'h01;
        tx_crc <= tx_crc_nx;
      end
      if (wr_do && aw_a == `MBF_OFF_TXCMD && w_d[`MBF_CMD_SEND]
          && stat.pending && !stat.bcast) begin
        tx_go <= 1'b1;
      end
      if (tx_go && rsp_ms >= `MBF_RSP_MIN_MS) begin
        tx_go <= 1'b0;
      end
      if (!stat.pending && !tx_go && !tx_en) begin
        tx_len <= 8'h00;
        tx_crc <= `MBF_CRC_INIT;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (ce && wr_do && aw_a == `MBF_OFF_TXDAT && !tx_en) begin
      tx_buf[tx_len[6:0]] <= w_d[7:0];
    end
  end

  // body bytes, then check field low byte first
  always_comb begin
    if (tx_pos == tx_len) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_pos == tx_len + 8'h01) begin
      tx_byte = tx_crc[15:8];
    end else begin
      tx_byte = tx_buf[tx_pos[6:0]];
    end
  end

  // serial transmitter; driver enable covers the whole reply
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_st <= MBF_IDLE;
      tx_cnt <= 12'h000;
      tx_bit <= 3'h0;
      tx_pos <= 8'h00;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
      txd <= 1'b1;
      tx_en <= 1'b0;
    end else if (ce) begin
      tx_cnt <= tx_cnt + 12'h001;
      case (tx_st)
        MBF_IDLE: begin
          tx_cnt <= 12'h000;
          txd <= 1'b1;
          if (tx_go && rsp_ms >= `MBF_RSP_MIN_MS) begin
            tx_en <= 1'b1;
            tx_pos <= 8'h00;
            tx_st <= MBF_START;
            txd <= 1'b0;
          end else begin
            tx_en <= 1'b0;
          end
        end
        MBF_START: begin
          if (tx_cnt == bit_lim) begin
            tx_cnt <= 12'h000;
            tx_bit <= 3'h0;
            txd <= tx_byte[0];
            tx_par <= ctrl.par[0] ^ tx_byte[0];
            tx_st <= MBF_DATA;
          end
        end
        MBF_DATA: begin
          if (tx_cnt == bit_lim) begin
            tx_cnt <= 12'h000;
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) begin
              tx_stop2 <= (ctrl.par == 2'd0);
              txd <= (ctrl.par == 2'd0) ? 1'b1 : tx_par;
              tx_st <= (ctrl.par == 2'd0) ? MBF_STOP : MBF_PAR;
            end else begin
              txd <= tx_byte[tx_bit + 3'h1];
              tx_par <= tx_par ^ tx_byte[tx_bit + 3'h1];
            end
          end
        end
        MBF_PAR: begin
          if (tx_cnt == bit_lim) begin
            tx_cnt <= 12'h000;
            txd <= 1'b1;
            tx_st <= MBF_STOP;
          end
        end
        MBF_STOP: begin
          if (tx_cnt == bit_lim && tx_stop2) begin
            tx_cnt <= 12'h000;
            tx_stop2 <= 1'b0; // second stop bit without parity
          end else if (tx_cnt == bit_lim) begin
            tx_cnt <= 12'h000;
            tx_pos <= tx_pos + 8'h01;
            if (tx_pos == tx_len + 8'h01) begin
              tx_st <= MBF_IDLE;
            end else begin
              txd <= 1'b0;
              tx_st <= MBF_START;
            end
          end
        end
        default: tx_st <= MBF_IDLE;
      endcase
    end
  end

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_got;
  assign s_axi_wready = !w_got;
  assign wr_do = aw_got && w_got && !s_axi_bvalid;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_a <= 5'h00;
      w_d <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MBF_RESP_OK;
      ctrl <= '0;
      rx_idx <= 7'h00;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_got) begin
        aw_got <= 1'b1;
        aw_a <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && !w_got) begin
        w_got <= 1'b1;
        w_d <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_do) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_a > `MBF_OFF_TXCMD) ? `MBF_RESP_ERR : `MBF_RESP_OK;
        if (aw_a == `MBF_OFF_CTRL) begin
          // byte lanes honoured only for the control word
          for (int b = 0; b < 4; b++) begin
            if (s_axi_wstrb[b]) begin
              ctrl[b*8 +: 8] <= w_d[b*8 +: 8];
            end
          end
        end
        if (aw_a == `MBF_OFF_RXIDX) begin
          rx_idx <= w_d[6:0];
        end
      end
    end
  end

  // axi4-lite read: one word per request, unmapped answers slverr
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MBF_RESP_OK;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MBF_RESP_OK;
        case ({s_axi_araddr[4:2], 2'b00})
          `MBF_OFF_CTRL: s_axi_rdata <= ctrl;
          `MBF_OFF_STAT: s_axi_rdata <= {8'h00, stat};
          `MBF_OFF_RXIDX: s_axi_rdata <= {25'h0000000, rx_idx};
          `MBF_OFF_RXDAT: s_axi_rdata <= {24'h000000, rx_buf[rx_idx]};
          `MBF_OFF_TXDAT: s_axi_rdata <= {24'h000000, tx_len};
          `MBF_OFF_TXCMD: s_axi_rdata <= {16'h0000, rsp_ms};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MBF_RESP_ERR;
          end
        endcase
      end
    end
  end

  // checks
  a_crc_restart:
    assert property (@(posedge ref_clk) disable iff (rst)
      ce && fr_end && !rx_stb |=> rx_crc == `MBF_CRC_INIT)
    else $error("crc not preloaded after frame end");
  a_silence_end:
    assert property (@(posedge ref_clk) disable iff (rst)
      fr_end |-> sil_cnt == sil_lim && $past(rx_st) == MBF_IDLE)
    else $error("frame closed without full silence");
  a_addr_filter:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(stat.pending) |-> rx_buf[0] == ctrl.addr || rx_buf[0] == `MBF_BCAST)
    else $error("frame accepted for foreign address");
  a_bcast_codes:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(stat.pending) && stat.bcast |-> stat.fc inside {`MBF_FC_WR_BIT,
        `MBF_FC_WR_REG, `MBF_FC_WR_BITS, `MBF_FC_WR_REGS})
    else $error("broadcast accepted for read code");
  a_bcast_silent:
    assert property (@(posedge ref_clk) disable iff (rst)
      stat.pending && stat.bcast |-> !$rose(tx_en))
    else $error("reply sent to broadcast");
  a_reply_delay:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(tx_en) |-> $past(rsp_ms) >= `MBF_RSP_MIN_MS && !txd)
    else $error("reply started before minimum delay");
  a_parity_drop:
    assert property (@(posedge ref_clk) disable iff (rst)
      ce && fr_end && fr_bad |=> !$rose(stat.pending) && stat.par_err)
    else $error("faulty frame accepted");
  a_crc_drop:
    assert property (@(posedge ref_clk) disable iff (rst)
      ce && fr_end && !fr_bad && fr_len >= `MBF_MIN_LEN && rx_crc != 16'h0000
        |=> stat.crc_err && !$rose(stat.pending))
    else $error("bad check field not discarded");
endmodule

// ==== bench/mbf_master_model.sv ====
/* bench partner: one rtu bus master on the serial pair.
 * assumes bit timing given in ref_clk cycles and an idle-high line. */
`timescale 1ns/10ps
module mbf_master_model #(
  parameter int BIT_CYC = 520
) (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd
);
  logic [1:0] par = 2'd0; // 0 none, 1 odd, 2 even, set like the slave
  logic [7:0] got_q[$]; // bytes heard from the slave
  initial rxd = 1'b1; // idle high, so silence marks the frame ends
  // one line level for one bit time
  task automatic hold(input logic v);
    rxd <= v;
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask
  // start, data lsb first, parity or a second stop, stop
  task automatic send_byte(input logic [7:0] b);
    hold(1'b0);
    for (int i = 0; i < 8; i++) hold(b[i]);
    hold(par == 2'd0 ? 1'b1 : (^b) ^ (par == 2'd1));
    hold(1'b1);
  endtask
  // bytes back to back; address 0 only for broadcast
  task automatic send_frame(input logic [7:0] q[$]);
    @(posedge ref_clk);
    foreach (q[i]) send_byte(q[i]);
  endtask
  // receiver samples each data bit in its middle
  always begin
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      b[i] = txd;
    end
    got_q.push_back(b);
    repeat (BIT_CYC * 2) @(posedge ref_clk);
  end
endmodule

// ==== bench/tb_modbus_rtu_slave_framer.sv ====
/* bench top: frame engine, rtu master model, axi4-lite master tasks.
 * assumes short ms and silence counts; the serial link runs at 38400. */
`timescale 1ns/10ps
module tb_modbus_rtu_slave_framer;
  logic ref_clk = 0, rst = 1, rxd, txd, tx_en;
  logic [4:0] aw_a = 0, ar_a = 0;
  logic [31:0] wd = 0, rdata, rd_v;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, bs_v, rs_v;
  logic ce = 1; // clock enable, dropped once to prove that state freezes
  logic [7:0] f, d, rq[$];
  logic [7:0] tbl[3] = '{8'h01, 8'h03, 8'h2b};
  logic [15:0] c;
  int fail_count = 0, check_count = 0, n;
  integer seed = 32'h191f;
  mbf_framer #(.SIL_9600_CYC(8000), .SIL_19200_CYC(4000), .SIL_38400_CYC(2000),
    .MS_CYC(20)) u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .rxd(rxd), .txd(txd),
    .tx_en(tx_en), .s_axi_awaddr(aw_a), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar_a),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  mbf_master_model u_mst (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  initial forever #25 ref_clk = ~ref_clk;
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      $display("BAD %0t %s", $time, m);
      fail_count++;
    end
  endtask
  // address and data offered together, each dropped once taken
  task axw(input logic [4:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    aw_a <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge ref_clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (!bv);
    bs_v = bresp;
    br <= 0;
  endtask
  task axr(input logic [4:0] a);
    @(posedge ref_clk);
    ar_a <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge ref_clk);
      if (arr) arv <= 0;
    end while (!rv);
    rd_v = rdata;
    rs_v = rresp;
    rr <= 0;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] a = 16'hffff;
    foreach (q[i]) begin
      a[7:0] = a[7:0] ^ q[i];
      for (int k = 0; k < 8; k++) a = a[0] ? (a >> 1) ^ 16'ha001 : a >> 1;
    end
    return a;
  endfunction
  // a 4-byte request, optionally with a spoiled check field, then silence
  task frm(input logic [7:0] a, fc, input logic bad);
    logic [7:0] q[$];
    logic [15:0] k;
    q = {a, fc};
    k = crc16(q);
    q.push_back(k[7:0] ^ {7'h0, bad});
    q.push_back(k[15:8]);
    u_mst.send_frame(q);
    repeat (2500) @(posedge ref_clk);
    $display("test frame %h %h done", a, fc);
  endtask
  initial begin
    repeat (140000) @(posedge ref_clk); // four frames and one reply need about 121000
    fail_count++;
    $display("BAD %0t timeout", $time);
    test_done;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    axr(5'h00); chk(rd_v, 32'h0, "ctrl reset");
    axr(5'h18); chk({30'h0, rs_v}, 32'h2, "unmapped read");
    axw(5'h18, 32'h0); chk({30'h0, bs_v}, 32'h2, "unmapped write");
    axw(5'h00, 32'h1a05); u_mst.par = 2'd2;
    axr(5'h00); chk(rd_v, 32'h1a05, "ctrl rw");
    // the ms counter would gain five steps in 100 running cycles
    axr(5'h14);
    c = rd_v[15:0];
    ce <= 0;
    repeat (100) @(posedge ref_clk);
    ce <= 1;
    axr(5'h14);
    chk({31'h0, (rd_v[15:0] - c) > 16'h0001}, 32'h0, "ce freeze");
    f = tbl[$unsigned($random(seed)) % 3];
    d = $random(seed);
    frm(8'h05, f, 0);
    axr(5'h04); chk(rd_v, {8'h0, f, 8'h04, 8'h01}, "accept");
    axw(5'h10, {24'h0, d});
    axw(5'h14, 32'h1);
    n = 0;
    while (u_mst.got_q.size() < 3 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    rq = {d};
    c = crc16(rq);
    chk({8'h0, u_mst.got_q[0], u_mst.got_q[1], u_mst.got_q[2]}, {8'h0, d, c[7:0], c[15:8]}, "reply");
    repeat (1500) @(posedge ref_clk);
    axr(5'h04); chk(rd_v & 32'h11, 32'h0, "reply done");
    frm(8'h05, 8'h03, 1);
    axr(5'h04); chk(rd_v & 32'h3, 32'h2, "bad check");
    axw(5'h04, 32'h0);
    axr(5'h04); chk(rd_v & 32'h2, 32'h0, "clear error");
    frm(8'h06, 8'h03, 0);
    axr(5'h04); chk(rd_v & 32'h1, 32'h0, "other addr");
    frm(8'h00, 8'h06, 0);
    axr(5'h04); chk(rd_v & 32'h9, 32'h9, "bcast");
    axw(5'h14, 32'h1);
    repeat (600) @(posedge ref_clk);
    chk({31'h0, tx_en}, 32'h0, "bcast silent");
    chk(u_mst.got_q.size(), 32'h3, "no bcast reply");
    axw(5'h14, 32'h2);
    axr(5'h04); chk(rd_v & 32'h1, 32'h0, "drop");
    $display("test registers and frames done");
    test_done;
  end
endmodule
